// ---- pic_cond.sv ----
// one channel of process input conditioning: settings, scaling, unit, shift and filter
// assumes raw samples, run flag and input type come from logic on i_mclk (no synchroniser)
`timescale 1ns/100ps
// ============================================================
// conditioning top
// ============================================================
// Summary of operation
// - unit 0 celsius, 1 fahrenheit, default 0
// - unit applies to temperature inputs only
// - compensation 0 external, 1 internal, default 1
// - compensation applies to thermocouple, infrared only
// - unit, compensation, scaling, point locked while running
// - scaling and point ignored for temperature inputs
// - analog range maps lower to upper limit
// - point gives fractional digits, default 1
// - larger scaling limit acts as upper limit
// - add straight-line correction through two points
// - equal shifts give constant offset everywhere
// - shifts use sensor point, 0 read as 1
// - first-order filter, 0.0 to 999.9 s, default 0
module pic_cond
  import pic_pkg::*;
#(
  parameter int RAW_BITS  = 12,                // analog sample resolution
  parameter int SAMPLE_MS = 100                // sample interval, ms
) (
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  input  wire logic               i_run,       // high while operation runs
  input  wire logic [4:0]         i_input_type,
  input  wire logic               i_cfg_wr,    // setting write strobe
  input  wire logic [3:0]         i_cfg_sel,
  input  wire logic signed [15:0] i_cfg_data,
  input  wire logic               i_raw_valid, // sample strobe
  input  wire logic signed [15:0] i_raw,       // tenths degC, or analog code
  input  wire logic signed [15:0] i_cj_temp,   // terminal temperature, tenths degC
  output logic                    o_cfg_ack,
  output logic                    o_cfg_rej,
  output logic signed [W-1:0]     o_pv,
  output logic                    o_pv_valid,
  output logic [1:0]              o_pv_dp,
  output logic                    o_busy,
  output logic                    o_unit_f,
  output logic                    o_cjc_int
);
  localparam logic [W-1:0] RAW_FS  = W'((1 << RAW_BITS) - 1);
  localparam logic [W-1:0] SMP_MS  = W'(SAMPLE_MS);

  // ============================================================
  // settings
  // ============================================================
  logic               next_unit_f, next_cjc_int, next_ack, next_rej;
  logic signed [15:0] sc_hi, sc_lo, iv1, sh1, iv2, sh2;   // scaling and shift points
  logic signed [15:0] next_sc_hi, next_sc_lo, next_iv1, next_sh1, next_iv2, next_sh2;
  logic [15:0]        tau, next_tau;                      // filter constant, 0.1 s
  logic [1:0]         dp, next_dp;                        // analog decimal point

  // write decode; locked settings bounce while running
  always_comb begin
    logic locked;
    locked       = (i_cfg_sel <= SEL_DP);
    next_unit_f  = o_unit_f;
    next_cjc_int = o_cjc_int;
    next_sc_hi   = sc_hi;
    next_sc_lo   = sc_lo;
    next_dp      = dp;
    next_iv1     = iv1;
    next_sh1     = sh1;
    next_iv2     = iv2;
    next_sh2     = sh2;
    next_tau     = tau;
    next_ack     = 1'b0;
    next_rej     = 1'b0;
    if (i_cfg_wr) begin
      if ((locked && i_run) || i_cfg_sel > SEL_FILT) begin
        next_rej = 1'b1;
      end else begin
        next_ack = 1'b1;
        if (i_cfg_sel == SEL_UNIT) begin
          next_unit_f = i_cfg_data[0];
        end else if (i_cfg_sel == SEL_CJC) begin
          next_cjc_int = i_cfg_data[0];
        end else if (i_cfg_sel == SEL_SC_HI) begin
          next_sc_hi = i_cfg_data;
        end else if (i_cfg_sel == SEL_SC_LO) begin
          next_sc_lo = i_cfg_data;
        end else if (i_cfg_sel == SEL_DP) begin
          next_dp = i_cfg_data[1:0];
        end else if (i_cfg_sel == SEL_IV1) begin
          next_iv1 = i_cfg_data;
        end else if (i_cfg_sel == SEL_SH1) begin
          next_sh1 = i_cfg_data;
        end else if (i_cfg_sel == SEL_IV2) begin
          next_iv2 = i_cfg_data;
        end else if (i_cfg_sel == SEL_SH2) begin
          next_sh2 = i_cfg_data;
        end else begin
          // negative or oversized constants clamp into range
          if (i_cfg_data[15]) begin
            next_tau = '0;
          end else if (i_cfg_data > $signed(FILT_MAX)) begin
            next_tau = FILT_MAX;
          end else begin
            next_tau = i_cfg_data;
          end
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_unit_f  <= RST_UNIT;
      o_cjc_int <= RST_CJC;
      sc_hi     <= RST_SC_HI;
      sc_lo     <= RST_SC_LO;
      dp        <= RST_DP;
      iv1       <= RST_IV1;
      sh1       <= RST_SH1;
      iv2       <= RST_IV2;
      sh2       <= RST_SH2;
      tau       <= RST_FILT;
      o_cfg_ack <= 1'b0;
      o_cfg_rej <= 1'b0;
    end else begin
      o_unit_f  <= next_unit_f;
      o_cjc_int <= next_cjc_int;
      sc_hi     <= next_sc_hi;
      sc_lo     <= next_sc_lo;
      dp        <= next_dp;
      iv1       <= next_iv1;
      sh1       <= next_sh1;
      iv2       <= next_iv2;
      sh2       <= next_sh2;
      tau       <= next_tau;
      o_cfg_ack <= next_ack;
      o_cfg_rej <= next_rej;
    end
  end

  // ============================================================
  // input classification and effective settings
  // ============================================================
  logic               is_analog, is_tc_ir;
  logic signed [W-1:0] hi_eff, lo_eff;                    // ordered limits
  logic [1:0]         dp_eff;                             // point of the value

  assign is_analog = (i_input_type >= TYPE_AN_FIRST) && (i_input_type <= TYPE_AN_LAST);
  assign is_tc_ir  = ((i_input_type >= TYPE_TC_FIRST) && (i_input_type <= TYPE_IR_LAST))
                     || (i_input_type == TYPE_TC_EXTRA);
  assign hi_eff    = (sc_lo > sc_hi) ? W'(sc_lo) : W'(sc_hi);
  assign lo_eff    = (sc_lo > sc_hi) ? W'(sc_hi) : W'(sc_lo);
  assign dp_eff    = is_analog ? dp : DP_TEMP;

  // ============================================================
  // pipeline
  // ============================================================
  pic_state_t          state, next_state;                 // current step
  logic                pend, next_pend;                   // division in flight
  logic                primed, next_primed;               // filter holds a value
  logic signed [W-1:0] val, next_val;                     // working value
  logic signed [W-1:0] corr, next_corr;                   // shift correction
  logic signed [W-1:0] filt, next_filt;                   // filter state
  logic signed [W-1:0] next_pv;
  logic                next_pv_valid, next_busy;
  logic [1:0]          next_pv_dp;
  logic                div_start, div_done;
  logic signed [W-1:0] div_num, div_den, div_quo;

  pic_div #(.WD(W)) u_div (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_start (div_start),
    .i_num   (div_num),
    .i_den   (div_den),
    .o_done  (div_done),
    .o_quo   (div_quo)
  );

  // each step issues at most one division, then waits for its result
  always_comb begin
    logic signed [W-1:0] cel;
    cel           = W'(i_raw);
    next_state    = state;
    next_pend     = pend;
    next_primed   = primed;
    next_val      = val;
    next_corr     = corr;
    next_filt     = filt;
    next_pv       = o_pv;
    next_pv_valid = 1'b0;
    next_pv_dp    = o_pv_dp;
    div_start     = 1'b0;
    div_num       = '0;
    div_den       = DP_TEN;
    case (state)
      ST_IDLE: begin
        // samples arriving mid-pipeline are dropped
        if (i_raw_valid) begin
          next_pend = 1'b0;
          if (is_analog) begin
            next_val   = W'({{(16 - RAW_BITS){1'b0}}, i_raw[RAW_BITS-1:0]});
            next_state = ST_SCALE;
          end else begin
            if (is_tc_ir && o_cjc_int) begin
              cel = W'(i_raw) + W'(i_cj_temp);
            end
            next_val   = cel;
            next_state = o_unit_f ? ST_UNIT : ST_SHIFT;
          end
        end
      end
      ST_SCALE: begin
        if (!pend) begin
          div_start = 1'b1;
          div_num   = (hi_eff - lo_eff) * val;
          div_den   = RAW_FS;
          next_pend = 1'b1;
        end else if (div_done) begin
          next_val   = lo_eff + div_quo;
          next_pend  = 1'b0;
          next_state = ST_SHIFT;
        end
      end
      ST_UNIT: begin
        if (!pend) begin
          div_start = 1'b1;
          div_num   = val * F_MUL;
          div_den   = F_DIV;
          next_pend = 1'b1;
        end else if (div_done) begin
          next_val   = div_quo + F_OFS;
          next_pend  = 1'b0;
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!pend) begin
          // coincident reference inputs cannot define a slope
          if (sh1 == sh2 || iv1 == iv2) begin
            next_corr  = W'(sh1);
            next_state = ST_DPADJ;
          end else begin
            div_start = 1'b1;
            div_num   = (W'(sh2) - W'(sh1)) * (val - W'(iv1));
            div_den   = W'(iv2) - W'(iv1);
            next_pend = 1'b1;
          end
        end else if (div_done) begin
          next_corr  = W'(sh1) + div_quo;
          next_pend  = 1'b0;
          next_state = ST_DPADJ;
        end
      end
      ST_DPADJ: begin
        if (!pend) begin
          if (dp_eff == 2'h0) begin
            div_start = 1'b1;
            div_num   = corr;
            div_den   = DP_TEN;
            next_pend = 1'b1;
          end else begin
            next_val   = val + corr;
            next_state = ST_FILT;
          end
        end else if (div_done) begin
          next_val   = val + div_quo;
          next_pend  = 1'b0;
          next_state = ST_FILT;
        end
      end
      ST_FILT: begin
        if (!pend) begin
          if (tau == '0 || !primed) begin
            next_filt   = val;
            next_primed = 1'b1;
            next_state  = ST_OUT;
          end else begin
            // truncation can leave the output a few counts short of a step
            div_start = 1'b1;
            div_num   = (val - filt) * SMP_MS;
            div_den   = W'(tau) * TAU_UNIT_MS + SMP_MS;
            next_pend = 1'b1;
          end
        end else if (div_done) begin
          next_filt  = filt + div_quo;
          next_pend  = 1'b0;
          next_state = ST_OUT;
        end
      end
      ST_OUT: begin
        next_pv       = filt;
        next_pv_valid = 1'b1;
        next_pv_dp    = dp_eff;
        next_state    = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
        next_pend  = 1'b0;
      end
    endcase
    next_busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state      <= ST_IDLE;
      pend       <= 1'b0;
      primed     <= 1'b0;
      val        <= '0;
      corr       <= '0;
      filt       <= '0;
      o_pv       <= '0;
      o_pv_valid <= 1'b0;
      o_pv_dp    <= RST_DP;
      o_busy     <= 1'b0;
    end else begin
      state      <= next_state;
      pend       <= next_pend;
      primed     <= next_primed;
      val        <= next_val;
      corr       <= next_corr;
      filt       <= next_filt;
      o_pv       <= next_pv;
      o_pv_valid <= next_pv_valid;
      o_pv_dp    <= next_pv_dp;
      o_busy     <= next_busy;
    end
  end
endmodule : pic_cond

// ---- pic_cond_asserts.sv ----
// concurrent checks on the ports of one conditioning channel
// assumes a single clock i_mclk and async active-low reset i_rst_n
`timescale 1ns/100ps
// ============================================================
// port checker
// ============================================================
module pic_cond_asserts
  import pic_pkg::*;
#(
  parameter int RAW_BITS  = 12,                // analog sample resolution
  parameter int SAMPLE_MS = 100                // filter step interval, ms
) (
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  input  wire logic               i_run,
  input  wire logic [4:0]         i_input_type,
  input  wire logic               i_cfg_wr,
  input  wire logic [3:0]         i_cfg_sel,
  input  wire logic signed [15:0] i_cfg_data,
  input  wire logic               i_raw_valid,
  input  wire logic signed [15:0] i_raw,
  input  wire logic signed [15:0] i_cj_temp,
  input  wire logic               o_cfg_ack,
  input  wire logic               o_cfg_rej,
  input  wire logic signed [W-1:0] o_pv,
  input  wire logic               o_pv_valid,
  input  wire logic [1:0]         o_pv_dp,
  input  wire logic               o_busy,
  input  wire logic               o_unit_f,
  input  wire logic               o_cjc_int
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // write aimed at a setting frozen while running
  wire logic locked = i_run && (i_cfg_sel <= SEL_DP);
  // a sample is taken only while idle
  wire logic take   = i_raw_valid && !o_busy;
  wire logic analog = (i_input_type >= TYPE_AN_FIRST) && (i_input_type <= TYPE_AN_LAST);

  // ============================================================
  // setting writes
  // ============================================================
  a_wr_accept: assert property (i_cfg_wr && !locked && i_cfg_sel <= SEL_FILT |=> o_cfg_ack && !o_cfg_rej)
    else $error("legal setting write not acknowledged");
  a_wr_locked: assert property (i_cfg_wr && locked |=> o_cfg_rej && !o_cfg_ack)
    else $error("locked setting write not refused");
  a_locked_hold: assert property (i_cfg_wr && locked |=> $stable(o_unit_f) && $stable(o_cjc_int))
    else $error("locked write changed a setting");
  a_unit_set: assert property (i_cfg_wr && !i_run && i_cfg_sel == SEL_UNIT |=> o_unit_f == $past(i_cfg_data[0]))
    else $error("unit setting not taken");
  a_cjc_set: assert property (i_cfg_wr && !i_run && i_cfg_sel == SEL_CJC |=> o_cjc_int == $past(i_cfg_data[0]))
    else $error("compensation setting not taken");
  a_unit_keep: assert property (!(i_cfg_wr && i_cfg_sel == SEL_UNIT) |=> $stable(o_unit_f))
    else $error("unit changed without a write");

  // ============================================================
  // sample path
  // ============================================================
  a_temp_dp: assert property (o_pv_valid && !analog |-> o_pv_dp == DP_TEMP)
    else $error("temperature result not in tenths");
  a_take_busy: assert property (take |=> o_busy)
    else $error("sample taken but not busy");
  a_result_due: assert property (take |-> ##[5:200] o_pv_valid)
    else $error("result late");
  a_busy_end: assert property (o_busy ##1 !o_busy |-> o_pv_valid)
    else $error("busy dropped without a result");

  c_refused: cover property (o_cfg_rej);
  c_dp_none: cover property (o_pv_valid && o_pv_dp == 2'h0);
  c_result: cover property (o_busy ##1 o_pv_valid);
endmodule : pic_cond_asserts

bind pic_cond pic_cond_asserts #(.RAW_BITS(RAW_BITS), .SAMPLE_MS(SAMPLE_MS)) pic_cond_asserts_i (.*);

// ---- pic_pkg.sv ----
// package of shared constants and the sequential divider used by the conditioning pipeline
// assumes one clock i_mclk and an asynchronous active-low reset i_rst_n
// ============================================================
// shared constants
// ============================================================
package pic_pkg;
  localparam int          W              = 32;        // datapath width
  // configuration write selects
  localparam logic [3:0]  SEL_UNIT       = 4'h0;      // temperature unit
  localparam logic [3:0]  SEL_CJC        = 4'h1;      // compensation method
  localparam logic [3:0]  SEL_SC_HI      = 4'h2;      // scaling upper limit
  localparam logic [3:0]  SEL_SC_LO      = 4'h3;      // scaling lower limit
  localparam logic [3:0]  SEL_DP         = 4'h4;      // decimal point position
  localparam logic [3:0]  SEL_IV1        = 4'h5;      // first reference input
  localparam logic [3:0]  SEL_SH1        = 4'h6;      // first shift
  localparam logic [3:0]  SEL_IV2        = 4'h7;      // second reference input
  localparam logic [3:0]  SEL_SH2        = 4'h8;      // second shift
  localparam logic [3:0]  SEL_FILT       = 4'h9;      // filter time constant, 0.1 s units
  // values after reset
  localparam logic        RST_UNIT       = 1'b0;      // celsius
  localparam logic        RST_CJC        = 1'b1;      // internal
  localparam logic [15:0] RST_SC_HI      = 16'h03e8;  // 1000
  localparam logic [15:0] RST_SC_LO      = 16'h0000;
  localparam logic [1:0]  RST_DP         = 2'h1;
  localparam logic [15:0] RST_IV1        = 16'h0000;
  localparam logic [15:0] RST_SH1        = 16'h0000;
  localparam logic [15:0] RST_IV2        = 16'h03e8;  // 1000
  localparam logic [15:0] RST_SH2        = 16'h0000;
  localparam logic [15:0] RST_FILT       = 16'h0000;  // 0.0 s
  localparam logic [15:0] FILT_MAX       = 16'h270f;  // 999.9 s
  // input type codes
  localparam logic [4:0]  TYPE_TC_FIRST  = 5'h05;
  localparam logic [4:0]  TYPE_TC_LAST   = 5'h14;
  localparam logic [4:0]  TYPE_IR_FIRST  = 5'h15;
  localparam logic [4:0]  TYPE_IR_LAST   = 5'h18;
  localparam logic [4:0]  TYPE_AN_FIRST  = 5'h19;
  localparam logic [4:0]  TYPE_AN_LAST   = 5'h1d;
  localparam logic [4:0]  TYPE_TC_EXTRA  = 5'h1e;
  // arithmetic constants
  localparam logic [1:0]  DP_TEMP        = 2'h1;      // temperatures carried in tenths
  localparam logic [W-1:0] F_MUL         = 32'h0000_0009;
  localparam logic [W-1:0] F_DIV         = 32'h0000_0005;
  localparam logic [W-1:0] F_OFS         = 32'h0000_0140; // 32.0 degrees in tenths
  localparam logic [W-1:0] DP_TEN        = 32'h0000_000a; // one decimal digit
  localparam logic [W-1:0] TAU_UNIT_MS   = 32'h0000_0064; // 0.1 s in ms
  // pipeline states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_SCALE = 7'b0000010,
    ST_UNIT  = 7'b0000100,
    ST_SHIFT = 7'b0001000,
    ST_DPADJ = 7'b0010000,
    ST_FILT  = 7'b0100000,
    ST_OUT   = 7'b1000000
  } pic_state_t;
endpackage : pic_pkg

// ============================================================
// signed restoring divider, quotient truncated toward zero
// ============================================================
`timescale 1ns/100ps
module pic_div
  import pic_pkg::*;
#(
  parameter int WD = 32                        // operand width
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_start,   // ignored while busy
  input  wire logic signed [WD-1:0] i_num,
  input  wire logic signed [WD-1:0] i_den,     // caller keeps this non-zero
  output logic                      o_done,    // one-cycle pulse with o_quo valid
  output logic signed [WD-1:0]      o_quo
);
  localparam int CW = $clog2(WD) + 1;
  localparam logic [CW-1:0] CNT_FULL = CW'(WD);

  logic          busy,   next_busy;            // iteration in progress
  logic [CW-1:0] cnt,    next_cnt;             // bits left
  logic [WD-1:0] dvd,    next_dvd;             // dividend shifting out, quotient in
  logic [WD-1:0] rem,    next_rem;             // partial remainder
  logic [WD-1:0] dsr,    next_dsr;             // divisor magnitude
  logic          neg,    next_neg;             // result sign
  logic          next_done;
  logic [WD-1:0] next_quo;

  // one quotient bit per cycle; latency WD cycles after start
  always_comb begin
    logic [WD-1:0] trial;
    trial     = '0;
    next_busy = busy;
    next_cnt  = cnt;
    next_dvd  = dvd;
    next_rem  = rem;
    next_dsr  = dsr;
    next_neg  = neg;
    next_done = 1'b0;
    next_quo  = o_quo;
    if (!busy && i_start) begin
      next_busy = 1'b1;
      next_cnt  = CNT_FULL;
      next_dvd  = i_num[WD-1] ? -i_num : i_num;
      next_dsr  = i_den[WD-1] ? -i_den : i_den;
      next_rem  = '0;
      next_neg  = i_num[WD-1] ^ i_den[WD-1];
    end else if (busy) begin
      trial    = {rem[WD-2:0], dvd[WD-1]};
      next_dvd = {dvd[WD-2:0], 1'b0};
      if (trial >= dsr) begin                  // subtract fits
        next_rem    = trial - dsr;
        next_dvd[0] = 1'b1;
      end else begin
        next_rem = trial;
      end
      next_cnt = cnt - 1'b1;
      if (cnt == 1) begin                      // last bit
        next_busy = 1'b0;
        next_done = 1'b1;
        next_quo  = neg ? -next_dvd : next_dvd;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy   <= 1'b0;
      cnt    <= '0;
      dvd    <= '0;
      rem    <= '0;
      dsr    <= '0;
      neg    <= 1'b0;
      o_done <= 1'b0;
      o_quo  <= '0;
    end else begin
      busy   <= next_busy;
      cnt    <= next_cnt;
      dvd    <= next_dvd;
      rem    <= next_rem;
      dsr    <= next_dsr;
      neg    <= next_neg;
      o_done <= next_done;
      o_quo  <= next_quo;
    end
  end
endmodule : pic_div

// ---- pic_sensor.sv ----
// behavioural sensor front end feeding raw samples to the channel
// assumes the bench fires one-cycle requests just after a clock edge
`timescale 1ns/100ps
// ============================================================
// sensor model
// ============================================================
module pic_sensor (
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  input  wire logic               i_fire,      // one-cycle sample request
  input  wire logic signed [15:0] i_val,       // reading to present
  input  wire logic signed [15:0] i_cj,        // terminal temperature
  output logic                    o_raw_valid,
  output logic signed [15:0]      o_raw,
  output logic signed [15:0]      o_cj_temp
);
  logic signed [15:0] last;                    // last reading presented
  // remember the reading so the idle line can show its inverse
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last <= 16'h0000;
    end else if (i_fire) begin
      last <= i_val;
    end
  end
  // idle data is scrambled so a design reading it outside the strobe shows up
  assign o_raw_valid = i_fire;
  assign o_raw       = i_fire ? i_val : ~last;
  assign o_cj_temp   = i_cj;
endmodule : pic_sensor

// ---- pic_tb.sv ----
// self-checking bench for one conditioning channel
// assumes the checker is bound in and the sensor model feeds samples
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module testbench
  import pic_pkg::*;
;
  localparam int SMS = 100;                    // filter step, ms
  logic               i_mclk = 1'b0;
  logic               i_rst_n = 1'b0;
  logic               i_run = 1'b0;
  logic               i_cfg_wr = 1'b0;
  logic               fire = 1'b0;             // sensor request
  logic [4:0]         i_input_type = 5'h00;
  logic [3:0]         i_cfg_sel = 4'h0;
  logic signed [15:0] i_cfg_data = 16'h0000;
  logic signed [15:0] val = 16'h0000;          // reading for the sensor
  logic signed [15:0] cj = 16'h0000;           // terminal temperature
  logic               i_raw_valid, o_cfg_ack, o_cfg_rej, o_pv_valid, o_busy, o_unit_f, o_cjc_int;
  logic signed [15:0] i_raw, i_cj_temp;
  logic signed [31:0] o_pv;
  logic [1:0]         o_pv_dp;
  int                 miscompares = 0;
  int                 tests_run = 0;
  int                 st[10];                  // expected settings by select code
  int                 y;                       // expected filter state
  logic [31:0]        seed = 32'h1a2c221d;

  always #2 i_mclk = ~i_mclk;

  pic_cond #(.RAW_BITS(12), .SAMPLE_MS(SMS)) pic_cond_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_run(i_run),
    .i_input_type(i_input_type), .i_cfg_wr(i_cfg_wr), .i_cfg_sel(i_cfg_sel), .i_cfg_data(i_cfg_data),
    .i_raw_valid(i_raw_valid), .i_raw(i_raw), .i_cj_temp(i_cj_temp), .o_cfg_ack(o_cfg_ack),
    .o_cfg_rej(o_cfg_rej), .o_pv(o_pv), .o_pv_valid(o_pv_valid), .o_pv_dp(o_pv_dp), .o_busy(o_busy),
    .o_unit_f(o_unit_f), .o_cjc_int(o_cjc_int));
  pic_sensor pic_sensor_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_fire(fire), .i_val(val), .i_cj(cj),
    .o_raw_valid(i_raw_valid), .o_raw(i_raw), .o_cj_temp(i_cj_temp));

  // ============================================================
  // helpers
  // ============================================================
  function automatic int rnd(int n, int b);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed % 32'(n)) + b;
  endfunction : rnd

  // expected process value from the settings model
  function automatic int exp_pv(int t, int r, int c);
    int x, h, l, k;
    if (t >= 25 && t <= 29) begin
      h = (st[2] > st[3]) ? st[2] : st[3];
      l = (st[2] > st[3]) ? st[3] : st[2];
      x = l + (h - l) * (r & 4095) / 4095;
    end else begin
      x = r + ((st[1] == 1 && t >= 5 && t <= 30) ? c : 0);
      if (st[0] == 1) x = x * 9 / 5 + 320;
    end
    k = (st[6] == st[8] || st[5] == st[7]) ? st[6] : st[6] + (st[8] - st[6]) * (x - st[5]) / (st[7] - st[5]);
    if (t >= 25 && t <= 29 && st[4] == 0) k = k / 10;
    x = x + k;
    if (st[9] != 0) x = y + (x - y) * SMS / (st[9] * 100 + SMS);
    return x;
  endfunction : exp_pv

  // one setting write; refusal expected while locked or out of range
  task automatic cfg(int s, int d);
    bit ok;
    ok = s <= 9 && !(i_run && s <= 4);
    i_cfg_sel = 4'(s);
    i_cfg_data = 16'(d);
    i_cfg_wr = 1'b1;
    @(posedge i_mclk);
    #1;
    i_cfg_wr = 1'b0;
    `CHK({o_cfg_ack, o_cfg_rej}, {ok, !ok})
    if (ok) st[s] = (s < 2) ? (d & 1) : (s == 4) ? (d & 3) : (s == 9) ? ((d < 0) ? 0 : (d > 9999) ? 9999 : d) : d;
    @(posedge i_mclk);
    #1;
  endtask : cfg

  // one sample through the sensor; bounded wait for the result
  task automatic samp(int t, int r, int c);
    int e, n;
    i_input_type = 5'(t);
    e = exp_pv(t, r, c);
    val = 16'(r);
    cj = 16'(c);
    fire = 1'b1;
    @(posedge i_mclk);
    #1;
    fire = 1'b0;
    n = 0;
    while (o_pv_valid !== 1'b1 && n < 300) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    if (n == 300) begin
      miscompares++;
      wrap_up();
    end
    `CHK(o_pv, 32'(e))
    `CHK(o_pv_dp, (t >= 25 && t <= 29) ? 2'(st[4]) : 2'h1)
    `CHK({o_unit_f, o_cjc_int}, {1'(st[0]), 1'(st[1])})
    y = e;
  endtask : samp

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // ============================================================
  // main sequence: corners first, then random settings and samples, then filter corners
  // ============================================================
  initial begin
    int tp;
    st = '{0, 1, 1000, 0, 1, 0, 0, 1000, 0, 0};
    y = 0;
    repeat (3) @(posedge i_mclk);
    #1;
    i_rst_n = 1'b1;
    `CHK({o_unit_f, o_cjc_int, o_pv_dp}, 4'h5)
    samp(5, 200, 30);                          // internal junction, tau 0
    samp(30, -50, 25);                         // late thermocouple code
    cfg(0, 1);
    samp(1, 2000, 40);                         // fahrenheit, no junction term
    cfg(1, 0);
    samp(21, 100, 50);                         // external junction
    cfg(2, 0);
    cfg(3, 500);
    cfg(4, 0);
    samp(26, 4095, 0);                         // swapped limits, no decimals
    samp(26, 0, 0);
    cfg(6, 12);
    cfg(8, 12);
    samp(27, 2000, 0);                         // one-point shift
    cfg(5, 100);
    cfg(8, -30);
    samp(12, 700, 5);                          // two-point slope
    i_run = 1'b1;
    cfg(0, 0);
    cfg(4, 3);
    cfg(6, 5);
    cfg(12, 1);
    samp(28, 1234, 0);                         // locked settings kept
    i_run = 1'b0;
    repeat (60) begin
      for (int s = 0; s < 9; s++) if (rnd(3, 0) == 0) cfg(s, (s == 2 || s == 3 || s == 7) ? rnd(12000, -1999) : rnd(400, -199));
      tp = rnd(32, 0);
      samp(tp, (tp >= 25 && tp <= 29) ? rnd(4096, 0) : rnd(12000, -1999), rnd(400, -100));
    end
    cfg(9, 9);
    samp(2, 500, 0);                           // smoothing steps
    samp(2, 500, 0);
    cfg(9, -5);
    samp(2, 100, 0);                           // clamped to zero, pass-through
    wrap_up();
  end
endmodule : testbench
